// *** design/spimsp_clkgen.sv ***
`timescale 1ns/100ps
module spimsp_clkgen (
	// clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       rstn_in,
	// rate selection
	input  wire logic       run_in,
	input  wire logic       double_speed_in,
	input  wire logic [1:0] rate_in,
	// one pulse per half period of the serial clock
	output logic            tick_out
);

	logic [6:0] count;
	wire  [6:0] half_len;
	wire  [6:0] count_inc;
	wire        wrap;

	function automatic logic [6:0] half_count(input logic dbl, input logic [1:0] rate);
		unique case ({dbl, rate})
			3'b000: half_count = spimsp_pkg::HALF_DIV4;
			3'b001: half_count = spimsp_pkg::HALF_DIV16;
			3'b010: half_count = spimsp_pkg::HALF_DIV64;
			3'b011: half_count = spimsp_pkg::HALF_DIV128;
			3'b100: half_count = spimsp_pkg::HALF_DIV2;
			3'b101: half_count = spimsp_pkg::HALF_DIV8;
			3'b110: half_count = spimsp_pkg::HALF_DIV32;
			3'b111: half_count = spimsp_pkg::HALF_DIV64;
		endcase
	endfunction

	assign half_len  = half_count(double_speed_in, rate_in);
	assign count_inc = count + 7'h01;
	assign wrap      = run_in && (count_inc == half_len);

	// held at zero while stopped so every byte starts with a full half period
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count    <= 7'h00;
			tick_out <= 1'b0;
		end else begin
			count    <= (!run_in || wrap) ? 7'h00 : count_inc;
			tick_out <= wrap;
		end
	end

endmodule

// *** design/spimsp_top.sv ***
`timescale 1ns/100ps
// What this block does
// - drive data on one serial clock edge, capture on the opposite edge
// - four modes, polarity times two plus phase; modes 0,2 sample leading
// - interrupt when complete flag, irq enable and global enable all set
// - port enable cleared means no transfer activity at all
// - bit order one shifts lsb first, zero msb first, both directions
// - master select one means master, zero means slave
// - master with slave select input low: drop master bit, set complete flag
// - polarity one idles clock high; leading edge falling, else rising
// - phase zero samples leading edge, phase one samples trailing edge
// - rate bits with double speed pick divisor 4/16/64/128 or 2/8/32/64
// - slave ignores rate bits and follows the external serial clock
// - complete flag set at end of byte and on master select fault
// - complete flag clears on vector acknowledge or status read then data access
// - collision flag set by data write during a transfer
// - status read with collision set then data access clears both flags
// - status bits five to one read as zero
// - double speed bit halves the master divisor, shortest period two cycles
// - data write starts transmission in master mode, data read returns receive buffer
// - master clock runs exactly one byte then stops and flags completion
// - transmit single buffered, receive double buffered, unread byte overwritten
// - slave deselect resets shift logic, drops partial data, releases output
module spimsp_top (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rstn_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// processor interrupt side
	input  wire logic        global_irq_en_in,
	input  wire logic        irq_ack_in,
	output logic             irq_out,
	// serial clock pin
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe_out,
	// master-out data pin
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe_out,
	// master-in data pin
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe_out,
	// slave select pin and its direction
	input  wire logic        ss_n_in,
	input  wire logic        ss_is_input_in
);

	spimsp_pkg::spimsp_state_type state;
	spimsp_pkg::spimsp_state_type next_state;

	logic [7:0] ctrl;
	logic       double_speed;
	logic       complete_flag;
	logic       collision_flag;
	logic       complete_arm;
	logic       collision_arm;
	logic [7:0] tx_hold;
	logic [7:0] tx_shift;
	logic [7:0] rx_shift;
	logic [7:0] rx_buf;
	logic       out_bit;
	logic [3:0] edge_cnt;
	logic       sck_prev;
	logic       tick;

	function automatic logic first_bit(input logic [7:0] d, input logic lsb);
		first_bit = lsb ? d[0] : d[7];
	endfunction

	function automatic logic [7:0] shift_out(input logic [7:0] d, input logic lsb);
		shift_out = lsb ? {1'b0, d[7:1]} : {d[6:0], 1'b0};
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b, input logic lsb);
		shift_in = lsb ? {b, d[7:1]} : {d[6:0], b};
	endfunction

	// bus decode
	wire access     = psel_in && penable_in && pready_out;
	wire bus_wr     = access && pwrite_in;
	wire bus_rd     = access && !pwrite_in;
	wire hit_ctrl   = (paddr_in == spimsp_pkg::CTRL_OFFSET);
	wire hit_stat   = (paddr_in == spimsp_pkg::STATUS_OFFSET);
	wire hit_data   = (paddr_in == spimsp_pkg::DATA_OFFSET);
	wire mapped     = hit_ctrl || hit_stat || hit_data;
	wire ctrl_wr    = bus_wr && hit_ctrl;
	wire stat_wr    = bus_wr && hit_stat;
	wire stat_rd    = bus_rd && hit_stat;
	wire data_wr    = bus_wr && hit_data;
	wire data_acc   = access && hit_data;
	wire ready_next = psel_in && penable_in && !pready_out;

	// control fields
	wire port_en    = ctrl[spimsp_pkg::CTRL_PORT_EN_BIT];
	wire master     = ctrl[spimsp_pkg::CTRL_MASTER_BIT];
	wire lsb_first  = ctrl[spimsp_pkg::CTRL_BIT_ORDER_BIT];
	wire polarity   = ctrl[spimsp_pkg::CTRL_POLARITY_BIT];
	wire phase      = ctrl[spimsp_pkg::CTRL_PHASE_BIT];
	wire [1:0] rate = {ctrl[spimsp_pkg::CTRL_RATE_HI_BIT], ctrl[spimsp_pkg::CTRL_RATE_LO_BIT]};

	// selection and faults
	wire master_run = (state == spimsp_pkg::SPIMSP_MASTER);
	wire mode_fault = port_en && master && ss_is_input_in && !ss_n_in;
	wire slave_sel  = port_en && !master && !ss_n_in;

	// serial clock edges; a slave watches only the pin, never the divider
	wire m_edge     = master_run && tick;
	wire s_edge     = slave_sel && (sck_in != sck_prev);
	wire edge_now   = m_edge || s_edge;
	wire leading    = master ? (sck_out == polarity) : (sck_prev == polarity);
	wire sample_now = edge_now && (leading ^ phase);
	wire setup_now  = edge_now && !(leading ^ phase);
	wire last_edge  = edge_now && (edge_cnt == spimsp_pkg::EDGE_LAST);
	wire in_bit     = master ? miso_in : mosi_in;

	// the first slave edge already counts as busy, so a write there collides
	wire busy       = (state != spimsp_pkg::SPIMSP_IDLE) || s_edge;
	wire load_wr    = data_wr && !busy;
	wire collide    = data_wr && busy;
	wire start      = load_wr && port_en && master && !mode_fault;
	wire quiet      = !busy;

	wire [7:0] rx_next   = shift_in(rx_shift, in_bit, lsb_first);
	wire [7:0] rx_final  = sample_now ? rx_next : rx_shift;
	wire [7:0] load_src  = load_wr ? pwdata_in[7:0] : tx_hold;
	// with phase zero the first bit is on the wire before the first edge
	wire [7:0] tx_pre    = phase ? load_src : shift_out(load_src, lsb_first);
	wire       out_pre   = first_bit(load_src, lsb_first);

	wire cnt_clear  = !port_en || mode_fault || (!master && ss_n_in) ||
	                  (master && !master_run);
	wire [3:0] next_edge_cnt = cnt_clear ? 4'h0 : (edge_now ? edge_cnt + 4'h1 : edge_cnt);

	// flags: a set in the same cycle as a clear wins
	wire complete_set   = last_edge || mode_fault;
	wire complete_clr   = irq_ack_in || (data_acc && (complete_arm || collision_arm));
	wire collision_clr  = data_acc && collision_arm;
	wire next_complete  = complete_set || (complete_flag && !complete_clr);
	wire next_collision = collide || (collision_flag && !collision_clr);
	wire next_c_arm     = (stat_rd && complete_flag) || (complete_arm && !data_acc);
	wire next_w_arm     = (stat_rd && collision_flag) || (collision_arm && !data_acc);

	// the fault clears master select even against a software write in the same cycle
	wire [7:0] ctrl_wval = ctrl_wr ? pwdata_in[7:0] : ctrl;
	wire [7:0] next_ctrl = mode_fault ?
	                       (ctrl_wval & ~(8'h01 << spimsp_pkg::CTRL_MASTER_BIT)) :
	                       ctrl_wval;

	wire [7:0] status_val = {complete_flag, collision_flag, 5'h00, double_speed};
	wire [7:0] read_mux   = hit_ctrl ? ctrl :
	                        hit_stat ? status_val :
	                        hit_data ? rx_buf : 8'h00;

	wire next_sck   = master_run ? (tick ? !sck_out : sck_out) : polarity;
	wire next_irq   = complete_flag && ctrl[spimsp_pkg::CTRL_IRQ_EN_BIT] &&
	                  global_irq_en_in;

	always_comb begin
		next_state = state;
		unique case (state)
			spimsp_pkg::SPIMSP_IDLE: begin
				if (start)
					next_state = spimsp_pkg::SPIMSP_MASTER;
				else if (s_edge)
					next_state = spimsp_pkg::SPIMSP_SLAVE;
			end
			spimsp_pkg::SPIMSP_MASTER: begin
				if (!port_en || !master || mode_fault || last_edge)
					next_state = spimsp_pkg::SPIMSP_IDLE;
			end
			spimsp_pkg::SPIMSP_SLAVE: begin
				if (!slave_sel || last_edge)
					next_state = spimsp_pkg::SPIMSP_IDLE;
			end
			default: next_state = spimsp_pkg::SPIMSP_IDLE;
		endcase
	end

	spimsp_clkgen u_clkgen (
		.sys_clk_in      (sys_clk_in),
		.rstn_in         (rstn_in),
		.run_in          (master_run),
		.double_speed_in (double_speed),
		.rate_in         (rate),
		.tick_out        (tick)
	);

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= spimsp_pkg::SPIMSP_IDLE;
			edge_cnt <= 4'h0;
			sck_prev <= 1'b0;
		end else begin
			state <= next_state;
			edge_cnt <= next_edge_cnt;
			sck_prev <= sck_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl <= spimsp_pkg::CTRL_RESET;
			double_speed <= spimsp_pkg::DOUBLE_RESET[0];
		end else begin
			ctrl <= next_ctrl;
			if (stat_wr)
				double_speed <= pwdata_in[spimsp_pkg::STAT_DOUBLE_BIT];
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			complete_flag <= 1'b0;
			collision_flag <= 1'b0;
			complete_arm <= 1'b0;
			collision_arm <= 1'b0;
		end else begin
			complete_flag <= next_complete;
			collision_flag <= next_collision;
			complete_arm <= next_c_arm;
			collision_arm <= next_w_arm;
		end
	end

	// transmit side has one holding byte only; a write during a byte is refused
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_hold <= spimsp_pkg::DATA_RESET;
		end else if (load_wr) begin
			tx_hold <= pwdata_in[7:0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_shift <= spimsp_pkg::DATA_RESET;
			out_bit <= 1'b0;
		end else if (quiet) begin
			tx_shift <= tx_pre;
			out_bit <= out_pre;
		end else if (setup_now) begin
			tx_shift <= shift_out(tx_shift, lsb_first);
			out_bit <= first_bit(tx_shift, lsb_first);
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_shift <= 8'h00;
			rx_buf <= spimsp_pkg::DATA_RESET;
		end else begin
			if (cnt_clear && !start)
				rx_shift <= 8'h00;
			else if (sample_now)
				rx_shift <= rx_next;
			if (last_edge)
				rx_buf <= rx_final;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pready_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= ready_next;
			pslverr_out <= ready_next && !mapped;
			if (ready_next)
				prdata_out <= {24'h00_0000, pwrite_in ? 8'h00 : read_mux};
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sck_out <= 1'b0;
			sck_oe_out <= 1'b0;
			mosi_oe_out <= 1'b0;
			miso_oe_out <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			sck_out <= next_sck;
			sck_oe_out <= port_en && master;
			mosi_oe_out <= port_en && master;
			miso_oe_out <= slave_sel;
			irq_out <= next_irq;
		end
	end

	// both data pins carry the same shift output; the enables pick the driving one
	assign mosi_out = out_bit;
	assign miso_out = out_bit;

endmodule

// *** inc/spimsp_pkg.sv ***
package spimsp_pkg;

	// register byte addresses on the APB
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] DATA_OFFSET   = 8'h08;

	// control register fields
	localparam int CTRL_IRQ_EN_BIT     = 7;
	localparam int CTRL_PORT_EN_BIT    = 6;
	localparam int CTRL_BIT_ORDER_BIT  = 5;
	localparam int CTRL_MASTER_BIT     = 4;
	localparam int CTRL_POLARITY_BIT   = 3;
	localparam int CTRL_PHASE_BIT      = 2;
	localparam int CTRL_RATE_HI_BIT    = 1;
	localparam int CTRL_RATE_LO_BIT    = 0;

	// status register fields
	localparam int STAT_COMPLETE_BIT   = 7;
	localparam int STAT_COLLISION_BIT  = 6;
	localparam int STAT_DOUBLE_BIT     = 0;

	// values after reset
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [7:0] DOUBLE_RESET  = 8'h00;
	localparam logic [7:0] DATA_RESET    = 8'h00;

	// half periods of the serial clock in system clock cycles
	localparam logic [6:0] HALF_DIV4     = 7'h02;
	localparam logic [6:0] HALF_DIV16    = 7'h08;
	localparam logic [6:0] HALF_DIV64    = 7'h20;
	localparam logic [6:0] HALF_DIV128   = 7'h40;
	localparam logic [6:0] HALF_DIV2     = 7'h01;
	localparam logic [6:0] HALF_DIV8     = 7'h04;
	localparam logic [6:0] HALF_DIV32    = 7'h10;

	// sixteen clock edges make one byte
	localparam logic [3:0] EDGE_LAST     = 4'hF;

	typedef enum logic [1:0] {
		SPIMSP_IDLE   = 2'b00,
		SPIMSP_MASTER = 2'b01,
		SPIMSP_SLAVE  = 2'b10
	} spimsp_state_type;

endpackage

// *** tb/spimsp_peer.sv ***
`timescale 1ns/100ps
module spimsp_peer (
	// serial lines
	input  wire logic       sck_in,
	input  wire logic       mosi_in,
	input  wire logic       ss_n_in,
	output logic            miso_out,
	// frame format and data
	input  wire logic [1:0] mode_in,
	input  wire logic       lsb_first_in,
	input  wire logic [7:0] tx_in,
	output logic      [7:0] rx_out
);
	int n_out;
	int n_in;
	function automatic int pos(input int k);
		return lsb_first_in ? k : 7 - k;
	endfunction
	initial miso_out = 1'b0;
	always @(negedge ss_n_in) begin
		n_in = 0;
		n_out = 0;
		if (!mode_in[0]) begin
			miso_out = tx_in[pos(0)];
			n_out = 1;
		end
	end
	// a released line must not keep showing the last bit
	always @(posedge ss_n_in)
		miso_out = ~miso_out;
	always @(sck_in) begin
		if (!ss_n_in) begin
			if ((sck_in != mode_in[1]) ^ mode_in[0]) begin
				rx_out[pos(n_in)] = mosi_in;
				n_in++;
			end else if (n_out < 8) begin
				miso_out = tx_in[pos(n_out)];
				n_out++;
			end else
				miso_out = ~miso_out;
		end
	end
endmodule

// *** tb/spimsp_sva.sv ***
`timescale 1ns/100ps
module spimsp_sva (
	// clock, reset and apb
	input wire logic        sys_clk_in,
	input wire logic        rstn_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [7:0]  paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	// interrupt and pins
	input wire logic        global_irq_en_in,
	input wire logic        irq_out,
	input wire logic        sck_oe_out,
	input wire logic        mosi_oe_out,
	input wire logic        miso_oe_out,
	input wire logic        ss_n_in,
	input wire logic        ss_is_input_in
);
	wire mapped = paddr_in inside {spimsp_pkg::CTRL_OFFSET, spimsp_pkg::STATUS_OFFSET,
		spimsp_pkg::DATA_OFFSET};
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_setup;
		psel_in && !penable_in;
	endsequence
	sequence s_access;
		psel_in && penable_in;
	endsequence
	chk_one_wait: assert property (s_setup ##1 s_access |-> !pready_out ##1 pready_out)
		else $error("pready not in second access cycle");
	chk_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("pready longer than one cycle");
	chk_unmapped_err: assert property (pready_out |-> pslverr_out == !mapped)
		else $error("pslverr does not match address map");
	chk_status_resv: assert property (pready_out && !pwrite_in &&
		paddr_in == spimsp_pkg::STATUS_OFFSET |-> prdata_out[5:1] == 5'h00)
		else $error("reserved status bits not zero");
	chk_irq_masked: assert property (!global_irq_en_in |=> !irq_out)
		else $error("interrupt with global enable low");
	chk_pin_roles: assert property (sck_oe_out == mosi_oe_out && !(mosi_oe_out && miso_oe_out))
		else $error("pin directions disagree with role");
	chk_slave_release: assert property (ss_n_in |=> !miso_oe_out)
		else $error("miso driven while deselected");
	chk_mode_fault: assert property (sck_oe_out && ss_is_input_in && !ss_n_in
		|-> ##[1:2] !sck_oe_out)
		else $error("master kept after select fault");
endmodule
bind spimsp_top spimsp_sva u_sva (.sys_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
	.paddr_in, .prdata_out, .pready_out, .pslverr_out, .global_irq_en_in, .irq_out,
	.sck_oe_out, .mosi_oe_out, .miso_oe_out, .ss_n_in, .ss_is_input_in);

// *** tb/spimsp_tb_top.sv ***
`timescale 1ns/100ps
module spimsp_tb_top;
	localparam logic [7:0] CA = spimsp_pkg::CTRL_OFFSET;
	localparam logic [7:0] SA = spimsp_pkg::STATUS_OFFSET;
	localparam logic [7:0] DA = spimsp_pkg::DATA_OFFSET;
	logic        sys_clk_in, rstn_in, psel_in, penable_in, pwrite_in;
	logic [7:0]  paddr_in;
	logic [31:0] pwdata_in, prdata_out;
	logic        pready_out, pslverr_out, global_irq_en_in, irq_ack_in, irq_out;
	logic        sck_out, sck_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out;
	logic        ss_n_in, ss_is_input_in, tb_sck, tb_mosi, peer_miso, peer_ss_n, peer_lsb;
	logic [1:0]  peer_mode;
	logic [7:0]  peer_tx, peer_rx;
	int          errors, samples_checked, seed;
	wire         sck_w  = sck_oe_out ? sck_out : tb_sck;
	wire         mosi_w = mosi_oe_out ? mosi_out : tb_mosi;
	wire         miso_w = miso_oe_out ? miso_out : peer_miso;
	spimsp_top uut (.sys_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
		.pwdata_in, .prdata_out, .pready_out, .pslverr_out, .global_irq_en_in, .irq_ack_in,
		.irq_out, .sck_in(sck_w), .sck_out, .sck_oe_out, .mosi_in(mosi_w), .mosi_out,
		.mosi_oe_out, .miso_in(miso_w), .miso_out, .miso_oe_out, .ss_n_in, .ss_is_input_in);
	spimsp_peer u_peer (.sck_in(sck_w), .mosi_in(mosi_w), .ss_n_in(peer_ss_n),
		.miso_out(peer_miso), .mode_in(peer_mode), .lsb_first_in(peer_lsb), .tx_in(peer_tx),
		.rx_out(peer_rx));
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge sys_clk_in);
		errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		wrap_up();
	end
	task automatic check(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, d, output logic [31:0] q);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= {24'h000000, d};
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do
			@(posedge sys_clk_in);
		while (pready_out !== 1'b1);
		q = prdata_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		// one idle edge keeps psel from being assigned twice in one step
		@(posedge sys_clk_in);
	endtask
	task automatic wr(input logic [7:0] a, d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [7:0] a, exp);
		logic [31:0] q;
		apb(1'b0, a, 8'h00, q);
		check(q, {24'h000000, exp});
	endtask
	function automatic int half(input logic [1:0] c, input logic d);
		int b;
		b = (c == 2'b00) ? 2 : (c == 2'b01) ? 8 : (c == 2'b10) ? 32 : 64;
		return d ? b / 2 : b;
	endfunction
	task automatic mxfer(input logic [7:0] c, input logic dbl, col, ack, input logic [7:0] tx, px);
		int e, n, t0, h;
		logic last;
		peer_mode <= c[3:2];
		peer_lsb <= c[5];
		peer_tx <= px;
		tb_sck <= c[3];
		wr(SA, {7'h00, dbl});
		wr(CA, c);
		// let the idle level of the new polarity settle before selecting the peer
		@(posedge sys_clk_in);
		peer_ss_n <= 1'b0;
		wr(DA, tx);
		if (col)
			wr(DA, ~tx);
		{e, n, t0, h} = '0;
		last = c[3];
		while (e < 16 && n < 3000) begin
			@(posedge sys_clk_in);
			n++;
			if (sck_out !== last) begin
				h = (e == 1) ? n - t0 : h;
				t0 = n;
				e++;
				last = sck_out;
			end
		end
		repeat (2 * half(c[1:0], dbl) + 2) @(posedge sys_clk_in);
		check(32'(h), 32'(half(c[1:0], dbl)));
		check(32'({e[4:0], sck_out}), {26'h0000000, 5'h10, c[3]});
		check(32'(irq_out), 32'(c[7] & global_irq_en_in));
		peer_ss_n <= 1'b1;
		irq_ack_in <= ack;
		@(posedge sys_clk_in);
		irq_ack_in <= 1'b0;
		rdc(SA, {~ack, col, 5'h00, dbl});
		rdc(DA, px);
		rdc(SA, {7'h00, dbl});
		check(32'(peer_rx), 32'(tx));
	endtask
	task automatic sxfer(input logic [1:0] m, input logic lsb, input logic [7:0] mo, input int nb,
		output logic [7:0] got);
		int k;
		got = 8'h00;
		ss_n_in <= 1'b0;
		for (k = 0; k < nb; k++) begin
			if (!m[0])
				tb_mosi <= mo[lsb ? k : 7 - k];
			repeat (4) @(posedge sys_clk_in); // four cycles a level
			tb_sck <= ~tb_sck;
			if (m[0])
				tb_mosi <= mo[lsb ? k : 7 - k];
			else
				got[lsb ? k : 7 - k] = miso_w;
			repeat (4) @(posedge sys_clk_in);
			tb_sck <= ~tb_sck;
			if (m[0])
				got[lsb ? k : 7 - k] = miso_w;
		end
		repeat (4) @(posedge sys_clk_in);
		ss_n_in <= 1'b1;
		tb_mosi <= ~tb_mosi;
		repeat (4) @(posedge sys_clk_in);
	endtask
	initial begin
		int i;
		logic [7:0] c, t, r, got;
		logic [1:0] m;
		{seed, errors, samples_checked} = {32'd29, 64'd0};
		rstn_in = 1'b0;
		{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
		{global_irq_en_in, irq_ack_in, ss_is_input_in, tb_sck, tb_mosi} = '0;
		{ss_n_in, peer_ss_n} = 2'b11;
		{peer_mode, peer_lsb, peer_tx} = '0;
		repeat (12) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		@(posedge sys_clk_in);
		rdc(CA, 8'h00);
		rdc(SA, 8'h00);
		rdc(DA, 8'h00);
		wr(8'h0C, 8'hFF);
		rdc(CA, 8'h00);
		wr(SA, 8'hFF);
		rdc(SA, 8'h01);
		wr(CA, 8'h10);
		wr(DA, 8'h5A);
		repeat (20) @(posedge sys_clk_in);
		check(32'({sck_oe_out, sck_out}), 32'h00000000);
		rdc(SA, 8'h01);
		$display("test registers and disable done");
		for (i = 0; i < 8; i++) begin
			c = 8'($random(seed));
			global_irq_en_in <= i[1];
			mxfer({i[0], 1'b1, c[1], 1'b1, c[3:2], i[1:0]}, i[2], i == 7, i == 6,
				8'($random(seed)), 8'($random(seed)));
		end
		$display("test master done");
		wr(CA, 8'h50);
		ss_is_input_in <= 1'b1;
		ss_n_in <= 1'b0;
		repeat (4) @(posedge sys_clk_in);
		rdc(CA, 8'h40);
		rdc(SA, 8'h81);
		ss_n_in <= 1'b1;
		ss_is_input_in <= 1'b0;
		wr(DA, 8'h00);
		rdc(SA, 8'h01);
		$display("test fault done");
		for (i = 0; i < 4; i++) begin
			m = 2'(i);
			c = 8'($random(seed));
			t = 8'($random(seed));
			r = 8'($random(seed));
			tb_sck <= m[1];
			wr(CA, {2'b01, c[0], 1'b0, m, 2'b11});
			wr(DA, t);
			sxfer(m, c[0], ~r, 3, got);
			sxfer(m, c[0], r, 8, got);
			check(32'(got), 32'(t));
			rdc(SA, 8'h81);
			rdc(DA, r);
		end
		$display("test slave done");
		wrap_up();
	end
endmodule
